// *** hdl/config_reboot_id_io_ctrl.sv ***
module config_reboot_id_io_ctrl
	import cfg_svc_pkg::*;
#(
	parameter int PINS = PIN_COUNT,
	// 1: pull-select lives in the control word, 0: external pin
	parameter bit PULL_SEL_IN_CTRL = 1'b1,
	// Preset reboot address, fixed when the bitstream is built
	parameter logic [SPI_ADDR_WIDTH-1:0] PRESET_ADDR = 24'h00_0000,
	// Arbitrary neutral identifier value
	parameter logic [ID_WIDTH-1:0] ID_VALUE = 64'h0123_4567_89ab_cdef
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Configuration sequencing
	input wire logic boot_strap_master_spi_boot,
	input wire logic load_start,
	input wire logic load_done,
	// Control word written by the bitstream during loading
	input wire logic ctrl_wr,
	input wire logic [CTRL_WIDTH-1:0] ctrl_wdata,
	// External pull-select pin, variant without control word
	input wire logic config_pull_select_pin,
	// Reboot request from user logic
	input wire logic reboot_req_n,
	input wire logic reboot_addr_from_user,
	input wire logic [SPI_ADDR_WIDTH-1:0] reboot_user_addr,
	// Identifier link from user logic, on its own shift clock
	input wire logic id_shift_clk,
	input wire logic id_shift_en,
	input wire logic id_test_in,
	// User design pin drive
	input wire logic [PINS-1:0] user_pin_used,
	input wire logic [PINS-1:0] user_pin_oe,
	input wire logic [PINS-1:0] user_pin_out,
	// Pin control toward the pads
	output logic [PINS-1:0] pin_out,
	output logic [PINS-1:0] pin_oe,
	output logic [PINS-1:0] pin_pull_up,
	// Status and reboot
	output logic master_spi_boot,
	output logic loading,
	output logic user_mode,
	output logic config_pull_select,
	output logic reboot_start,
	output logic [SPI_ADDR_WIDTH-1:0] reboot_addr,
	// Identifier serial answer
	output logic id_dout
);

	// Pull-up for one pin in the given phase
	function automatic logic pull_for(cfg_state_t st, logic sel,
		logic used);
		logic p;
		p = 1'b0;
		case (st)
			ST_POWER_ON: p = 1'b0;
			ST_LOADING: p = ~sel;
			ST_USER: p = ~used;
			default: p = 1'b0;
		endcase
		return p;
	endfunction

	// Drive enable for one pin in the given phase
	function automatic logic oe_for(cfg_state_t st, logic used,
		logic oe);
		logic e;
		e = 1'b0;
		case (st)
			ST_USER: e = used & oe;
			default: e = 1'b0;
		endcase
		return e;
	endfunction

	// ------------------------------------------------------------
	// Link synchronisers
	// ------------------------------------------------------------

	id_link_t link_in; // Raw link bundle
	id_link_t sync1_q; // First stage, read by second only
	id_link_t sync2_q; // Second stage, safe to use
	id_link_t sync3_q; // Held copy for edge finding
	id_link_t sync1_d;
	id_link_t sync2_d;
	id_link_t sync3_d;
	logic pull_pin_s1_q; // Pull-select pin, first stage
	logic pull_pin_s2_q; // Pull-select pin, second stage
	logic pull_pin_s1_d;
	logic pull_pin_s2_d;

	assign link_in.shift_clk = id_shift_clk;
	assign link_in.shift_en = id_shift_en;
	assign link_in.test_in = id_test_in;

	// Next values of the synchroniser chain
	always_comb begin
		sync1_d = link_in;
		sync2_d = sync1_q;
		sync3_d = sync2_q;
		pull_pin_s1_d = config_pull_select_pin;
		pull_pin_s2_d = pull_pin_s1_q;
	end

	// Register the synchronisers; shift clock idles low
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_q <= '0;
			sync2_q <= '0;
			sync3_q <= '0;
			pull_pin_s1_q <= 1'b1;
			pull_pin_s2_q <= 1'b1;
		end else begin
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
			sync3_q <= sync3_d;
			pull_pin_s1_q <= pull_pin_s1_d;
			pull_pin_s2_q <= pull_pin_s2_d;
		end
	end

	// Rising shift edge seen after synchronising. The user clock
	// must stay at or below its limit so each full period spans
	// at least two system cycles and no edge is missed.
	logic shift_rise;
	assign shift_rise = sync2_q.shift_clk & ~sync3_q.shift_clk;

	// Enable and data are sampled at the rise; they were changed
	// on the falling edge so they stand a full half period.
	logic shift_pulse;
	assign shift_pulse = shift_rise & sync2_q.shift_en;

	// ------------------------------------------------------------
	// Identifier chain
	// ------------------------------------------------------------

	id_shift_chain #(
		.WIDTH(ID_WIDTH),
		.ID_VALUE(ID_VALUE)
	) u_chain (
		.clk(clk),
		.rst(rst),
		.shift_pulse(shift_pulse),
		.shift_en(sync2_q.shift_en),
		.test_in(sync2_q.test_in),
		.dout(id_dout)
	);

	// ------------------------------------------------------------
	// Boot strap capture
	// ------------------------------------------------------------

	logic strap_taken_q; // Strap captured since reset release
	logic strap_taken_d;
	logic master_spi_boot_q; // Captured master-SPI boot mode
	logic master_spi_boot_d;

	// The strap is caught once, on the first clock after release,
	// so the asynchronous reset only ever loads constants.
	always_comb begin
		strap_taken_d = 1'b1;
		master_spi_boot_d = master_spi_boot_q;
		if (!strap_taken_q) begin
			master_spi_boot_d = boot_strap_master_spi_boot;
		end
	end

	// Register the strap
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			strap_taken_q <= 1'b0;
			master_spi_boot_q <= 1'b0;
		end else begin
			strap_taken_q <= strap_taken_d;
			master_spi_boot_q <= master_spi_boot_d;
		end
	end

	// ------------------------------------------------------------
	// Pull-select source
	// ------------------------------------------------------------

	logic [CTRL_WIDTH-1:0] ctrl_q; // Control word from the bitstream
	logic [CTRL_WIDTH-1:0] ctrl_d;
	cfg_state_t state_q; // Configuration phase
	cfg_state_t state_d;

	// Only the bitstream writes the control word, so writes are
	// honoured during loading and ignored in every other phase.
	always_comb begin
		ctrl_d = ctrl_q;
		if (ctrl_wr && state_q == ST_LOADING) begin
			ctrl_d = ctrl_wdata;
		end
	end

	// Register the control word; it resets to pull-select high
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= CTRL_RESET;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// Select the variant; an undriven pin reads high through its
	// weak pull, matching the reset value of the other variant
	logic pull_sel;
	assign pull_sel = PULL_SEL_IN_CTRL ? ctrl_q[PULL_SEL_BIT]
		: pull_pin_s2_q;

	// ------------------------------------------------------------
	// Phase sequencer and reboot
	// ------------------------------------------------------------

	logic req_n_prev_q; // Previous reboot request level
	logic req_n_prev_d;
	logic reboot_go;
	reboot_t reboot_q; // Registered reboot command
	reboot_t reboot_d;

	// A new request is the drop of the line to 0 in user mode with
	// master-SPI boot; a line held low cannot trigger again.
	assign reboot_go = state_q == ST_USER && master_spi_boot_q
		&& !reboot_req_n && req_n_prev_q;

	// Phase and reboot next values
	always_comb begin
		state_d = state_q;
		req_n_prev_d = reboot_req_n;
		reboot_d.start = 1'b0;
		reboot_d.addr = reboot_q.addr;
		case (state_q)
			ST_POWER_ON: begin
				// Pins stay high-z until loading begins
				if (load_start) begin
					state_d = ST_LOADING;
				end
			end
			ST_LOADING: begin
				if (load_done) begin
					state_d = ST_USER;
				end
			end
			ST_USER: begin
				if (reboot_go) begin
					// Restart loading from the chosen address
					state_d = ST_LOADING;
					reboot_d.start = 1'b1;
					reboot_d.addr = reboot_addr_from_user
						? reboot_user_addr
						: PRESET_ADDR;
				end
			end
			default: begin
				state_d = ST_POWER_ON;
			end
		endcase
	end

	// Register phase and reboot command
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_POWER_ON;
			req_n_prev_q <= 1'b1;
			reboot_q <= '0;
		end else begin
			state_q <= state_d;
			req_n_prev_q <= req_n_prev_d;
			reboot_q <= reboot_d;
		end
	end

	// ------------------------------------------------------------
	// Pin control
	// ------------------------------------------------------------

	logic [PINS-1:0] pin_out_q; // Registered pad drive
	logic [PINS-1:0] pin_oe_q;
	logic [PINS-1:0] pin_pull_q;
	logic [PINS-1:0] pin_out_d;
	logic [PINS-1:0] pin_oe_d;
	logic [PINS-1:0] pin_pull_d;

	// Each pin takes its state from the next phase, so the pads
	// change in the same edge as the phase outputs do.
	generate
		for (genvar i = 0; i < PINS; i++) begin : g_pin
			always_comb begin
				pin_pull_d[i] = pull_for(state_d, pull_sel,
					user_pin_used[i]);
				pin_oe_d[i] = oe_for(state_d, user_pin_used[i],
					user_pin_oe[i]);
				pin_out_d[i] = pin_oe_d[i] & user_pin_out[i];
			end
		end
	endgenerate

	// Register pad controls; all pins high-z out of reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_out_q <= '0;
			pin_oe_q <= '0;
			pin_pull_q <= '0;
		end else begin
			pin_out_q <= pin_out_d;
			pin_oe_q <= pin_oe_d;
			pin_pull_q <= pin_pull_d;
		end
	end

	// ------------------------------------------------------------
	// Status outputs
	// ------------------------------------------------------------

	logic loading_q; // Phase flags, registered for clean outputs
	logic user_q;
	logic pull_sel_q;
	logic loading_d;
	logic user_d;
	logic pull_sel_d;

	// Phase flag next values follow the next phase; pull-select follows its source
	always_comb begin
		loading_d = state_d == ST_LOADING;
		user_d = state_d == ST_USER;
		pull_sel_d = pull_sel;
	end

	// Register status
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			loading_q <= 1'b0;
			user_q <= 1'b0;
			pull_sel_q <= PULL_SEL_RESET;
		end else begin
			loading_q <= loading_d;
			user_q <= user_d;
			pull_sel_q <= pull_sel_d;
		end
	end

	assign pin_out = pin_out_q;
	assign pin_oe = pin_oe_q;
	assign pin_pull_up = pin_pull_q;
	assign master_spi_boot = master_spi_boot_q;
	assign loading = loading_q;
	assign user_mode = user_q;
	assign config_pull_select = pull_sel_q;
	assign reboot_start = reboot_q.start;
	assign reboot_addr = reboot_q.addr;

endmodule

// *** hdl/cfg_svc_pkg.sv ***
// Behaviour
// - Reboot request falling low in user mode restarts flash loading, with master-SPI boot only
// - Reboot address from user or preset
// - Fixed 64-bit identifier, never altered
// - Serial port shifts identifier out
// - Test input bits shift into chain
// - Pins tri-stated before loading starts
// - Loading: pull-up when select 0, else high-z
// - User mode: design drives used, pulls unused
// - Control-word variant: bit 31, resets 1
// - Pin variant: external select, weak pull-up
package cfg_svc_pkg;

	// Identifier chain width
	localparam int ID_WIDTH = 64;
	// Flash address width for the reboot start point
	localparam int SPI_ADDR_WIDTH = 24;
	// Control word carrying the pull-select
	localparam int CTRL_WIDTH = 32;
	localparam int PULL_SEL_BIT = 31;
	localparam logic [31:0] CTRL_RESET = 32'h8000_0000;
	localparam logic PULL_SEL_RESET = 1'b1;
	// Default user pin count
	localparam int PIN_COUNT = 8;

	// System clock and shift clock limits
	localparam int SYS_CLK_PERIOD_NS = 20;
	localparam int ID_CLK_MAX_MHZ = 20;
	localparam int ID_CLK_MIN_PERIOD_NS = 1000 / ID_CLK_MAX_MHZ;
	// System cycles in one fastest shift clock period (rounded down)
	localparam int ID_CLK_MIN_CYCLES =
		ID_CLK_MIN_PERIOD_NS / SYS_CLK_PERIOD_NS;

	// Configuration phase of the device
	typedef enum logic [1:0] {
		ST_POWER_ON = 2'b00,
		ST_LOADING = 2'b01,
		ST_USER = 2'b10
	} cfg_state_t;

	// Identifier link signals from the fabric, one clock domain
	typedef struct packed {
		logic shift_clk;
		logic shift_en;
		logic test_in;
	} id_link_t;

	// Reboot request toward the flash loader
	typedef struct packed {
		logic start;
		logic [SPI_ADDR_WIDTH-1:0] addr;
	} reboot_t;

endpackage

// *** hdl/id_shift_chain.sv ***
module id_shift_chain
	import cfg_svc_pkg::*;
#(
	parameter int WIDTH = ID_WIDTH,
	// Arbitrary neutral identifier value, stands for the fused one
	parameter logic [63:0] ID_VALUE = 64'h0123_4567_89ab_cdef
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Synchronised link controls
	input wire logic shift_pulse,
	input wire logic shift_en,
	input wire logic test_in,
	// Serial answer
	output logic dout
);

	logic [WIDTH-1:0] chain_q; // Working copy of the identifier
	logic [WIDTH-1:0] chain_d;
	logic dout_q; // Registered serial output
	logic dout_d;

	// The fused value is a constant; only the copy moves, so the
	// identifier itself can never be lost. Reload while idle.
	always_comb begin
		chain_d = chain_q;
		dout_d = dout_q;
		if (!shift_en) begin
			chain_d = ID_VALUE[WIDTH-1:0];
			dout_d = ID_VALUE[WIDTH-1];
		end else if (shift_pulse) begin
			// Move one place, test bit enters at the far end
			chain_d = {chain_q[WIDTH-2:0], test_in};
			dout_d = chain_q[WIDTH-2];
		end
	end

	// Register the chain and the output bit
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			chain_q <= '0;
			dout_q <= 1'b0;
		end else begin
			chain_q <= chain_d;
			dout_q <= dout_d;
		end
	end

	assign dout = dout_q;

endmodule

// *** dv/cfg_svc_chk.sv ***
module cfg_svc_chk
	import cfg_svc_pkg::*;
#(
	parameter int PINS = PIN_COUNT,
	// 1: pull-select from the control word, 0: from the pad
	parameter bit PULL_SEL_IN_CTRL = 1'b1,
	parameter logic [SPI_ADDR_WIDTH-1:0] PRESET_ADDR = 24'h00_0000,
	parameter logic [ID_WIDTH-1:0] ID_VALUE = 64'h0123_4567_89ab_cdef
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Watched inputs
	input wire logic ctrl_wr,
	input wire logic [CTRL_WIDTH-1:0] ctrl_wdata,
	input wire logic reboot_req_n,
	input wire logic reboot_addr_from_user,
	input wire logic [SPI_ADDR_WIDTH-1:0] reboot_user_addr,
	input wire logic id_shift_en,
	input wire logic [PINS-1:0] user_pin_used,
	input wire logic [PINS-1:0] user_pin_oe,
	// Watched outputs
	input wire logic [PINS-1:0] pin_oe,
	input wire logic [PINS-1:0] pin_pull_up,
	input wire logic master_spi_boot,
	input wire logic loading,
	input wire logic user_mode,
	input wire logic config_pull_select,
	input wire logic reboot_start,
	input wire logic [SPI_ADDR_WIDTH-1:0] reboot_addr,
	input wire logic id_dout
);
	timeunit 1ns;
	timeprecision 100ps;

	// One domain, so clock and reset are given once
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_PRE_TRISTATE: assert property (!loading && !user_mode |->
		pin_oe == '0 && pin_pull_up == '0)
		else $error("pins not tri-stated before loading");
	AST_LOAD_PULL: assert property (loading |-> pin_oe == '0 &&
		pin_pull_up == {PINS{~config_pull_select}})
		else $error("pull state in loading wrong");
	AST_USER_PINS: assert property (user_mode && $past(user_mode) |->
		(pin_pull_up | $past(user_pin_used)) == '1 &&
		pin_oe == ($past(user_pin_oe) & $past(user_pin_used)))
		else $error("user mode pin control wrong");
	AST_SEL_CAUSE: assert property (PULL_SEL_IN_CTRL &&
		$changed(config_pull_select) |->
		$past(ctrl_wr, 2) && $past(loading, 2))
		else $error("pull-select changed without a write");
	AST_SEL_VALUE: assert property (PULL_SEL_IN_CTRL &&
		ctrl_wr && loading |=> ##1
		config_pull_select == $past(ctrl_wdata[PULL_SEL_BIT], 2))
		else $error("pull-select not taken from bit 31");
	AST_REBOOT_GO: assert property (user_mode && master_spi_boot &&
		$fell(reboot_req_n) |=> reboot_start && loading &&
		reboot_addr == ($past(reboot_addr_from_user) ?
		$past(reboot_user_addr) : PRESET_ADDR))
		else $error("reboot not started at the right address");
	AST_REBOOT_CAUSE: assert property ($rose(reboot_start) |->
		$past(user_mode) && !$past(reboot_req_n) && $past(reboot_req_n, 2))
		else $error("reboot without a falling request");
	AST_REBOOT_PULSE: assert property (reboot_start |=> !reboot_start)
		else $error("reboot start longer than one cycle");
	AST_ID_RELOAD: assert property (!id_shift_en [*5] |->
		id_dout == ID_VALUE[ID_WIDTH-1])
		else $error("identifier not reloaded while idle");
endmodule

bind config_reboot_id_io_ctrl cfg_svc_chk #(.PINS(PINS),
	.PULL_SEL_IN_CTRL(PULL_SEL_IN_CTRL),
	.PRESET_ADDR(PRESET_ADDR), .ID_VALUE(ID_VALUE)) u_chk (
	.clk(clk), .rst(rst), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
	.reboot_req_n(reboot_req_n),
	.reboot_addr_from_user(reboot_addr_from_user),
	.reboot_user_addr(reboot_user_addr), .id_shift_en(id_shift_en),
	.user_pin_used(user_pin_used), .user_pin_oe(user_pin_oe),
	.pin_oe(pin_oe), .pin_pull_up(pin_pull_up),
	.master_spi_boot(master_spi_boot), .loading(loading),
	.user_mode(user_mode), .config_pull_select(config_pull_select),
	.reboot_start(reboot_start), .reboot_addr(reboot_addr),
	.id_dout(id_dout));

// *** dv/id_link_model.sv ***
module id_link_model
	import cfg_svc_pkg::*;
(
	// Serial answer from the device
	input wire logic id_dout,
	// Link toward the device
	output id_link_t link
);
	timeunit 1ns;
	timeprecision 100ps;

	// Shift clock stands low between frames
	initial link = '{shift_clk: 1'b0, shift_en: 1'b0, test_in: 1'b0};

	// 64 identifier bits then two test bits; bit read just before each rise
	task automatic run(input int hp, input logic [1:0] tin,
		output logic [65:0] got);
		for (int k = 0; k < 66; k++) begin
			// Enable and data move only while the clock is low
			link.shift_en = 1'b1;
			link.test_in = (k < 2) ? tin[k] : ~link.test_in;
			#(hp);
			got[65-k] = id_dout;
			// Half period of at least 25 ns keeps the rate legal
			link.shift_clk = 1'b1;
			#(hp);
			link.shift_clk = 1'b0;
		end
		link.shift_en = 1'b0;
		// Released data line shows no stale value
		link.test_in = ~link.test_in;
	endtask
endmodule

// *** dv/config_reboot_id_io_ctrl_test.sv ***
module config_reboot_id_io_ctrl_test
	import cfg_svc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	// Arbitrary identifier value for the bench
	localparam logic [ID_WIDTH-1:0] ID_V = 64'h5a3c_0f96_1e2d_4b87;
	localparam logic [SPI_ADDR_WIDTH-1:0] PRESET_V = 24'h00_0100;

	logic clk, rst, load_start, load_done, ctrl_wr, reboot_req_n, from_user;
	logic strap, pin_sel, pull_sel_p; // Boot strap, pad select, its effect
	logic [PIN_COUNT-1:0] pull_up_p; // Pull-ups of the pad-select variant
	logic [CTRL_WIDTH-1:0] ctrl_wdata;
	logic [SPI_ADDR_WIDTH-1:0] user_addr, reboot_addr;
	logic [PIN_COUNT-1:0] used, uoe, uout, pin_out, pin_oe, pin_pull_up;
	logic master_spi_boot, loading, user_mode, pull_sel, reboot_start;
	logic id_dout;
	id_link_t link;
	int error_cnt, compares;

	config_reboot_id_io_ctrl #(.PRESET_ADDR(PRESET_V), .ID_VALUE(ID_V)) DUT (
		.clk(clk), .rst(rst), .boot_strap_master_spi_boot(strap),
		.load_start(load_start), .load_done(load_done), .ctrl_wr(ctrl_wr),
		.ctrl_wdata(ctrl_wdata), .config_pull_select_pin(1'b1),
		.reboot_req_n(reboot_req_n), .reboot_addr_from_user(from_user),
		.reboot_user_addr(user_addr), .id_shift_clk(link.shift_clk),
		.id_shift_en(link.shift_en), .id_test_in(link.test_in),
		.user_pin_used(used), .user_pin_oe(uoe), .user_pin_out(uout),
		.pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_up(pin_pull_up),
		.master_spi_boot(master_spi_boot), .loading(loading),
		.user_mode(user_mode), .config_pull_select(pull_sel),
		.reboot_start(reboot_start), .reboot_addr(reboot_addr),
		.id_dout(id_dout));

	// Pad-select variant; only its pull-select effect is compared
	config_reboot_id_io_ctrl #(.PULL_SEL_IN_CTRL(1'b0),
		.PRESET_ADDR(PRESET_V), .ID_VALUE(ID_V)) DUT_PIN (
		.clk(clk), .rst(rst), .boot_strap_master_spi_boot(strap),
		.load_start(load_start), .load_done(load_done), .ctrl_wr(ctrl_wr),
		.ctrl_wdata(ctrl_wdata), .config_pull_select_pin(pin_sel),
		.reboot_req_n(reboot_req_n), .reboot_addr_from_user(from_user),
		.reboot_user_addr(user_addr), .id_shift_clk(link.shift_clk),
		.id_shift_en(link.shift_en), .id_test_in(link.test_in),
		.user_pin_used(used), .user_pin_oe(uoe), .user_pin_out(uout),
		.pin_out(), .pin_oe(), .pin_pull_up(pull_up_p),
		.master_spi_boot(), .loading(), .user_mode(),
		.config_pull_select(pull_sel_p), .reboot_start(),
		.reboot_addr(), .id_dout());

	// User logic on the identifier link
	id_link_model u_user (.id_dout(id_dout), .link(link));

	always #10 clk = ~clk;

	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop;
		if (error_cnt == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Inputs always move 2 ns after the rising edge
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask

	task automatic t_reset;
		chk(pull_sel, 1'b1);
		chk({pin_oe, pin_pull_up}, 16'h0000);
		chk(master_spi_boot, 1'b1);
		chk(pull_sel_p, 1'b1);
	endtask

	task automatic t_load;
		pin_sel = 1'b0;
		load_start = 1'b1;
		step(1);
		load_start = 1'b0;
		chk({loading, pin_pull_up}, 9'h100);
		ctrl_wr = 1'b1;
		step(1);
		ctrl_wr = 1'b0;
		step(2);
		chk({pull_sel, pin_oe, pin_pull_up}, 17'h000ff);
		chk({pull_sel_p, pull_up_p}, 9'h0ff);
		load_done = 1'b1;
		step(1);
		load_done = 1'b0;
		step(1);
		chk({user_mode, pin_oe}, 9'h105);
		chk({pin_pull_up & 8'hf0, pin_out & pin_oe}, 16'hf001);
		// A write in user mode must be ignored
		ctrl_wdata = 32'h8000_0000;
		ctrl_wr = 1'b1;
		step(1);
		ctrl_wr = 1'b0;
		step(2);
		chk(pull_sel, 1'b0);
	endtask

	task automatic t_reboot(input logic usr, input logic [23:0] exp);
		from_user = usr;
		reboot_req_n = 1'b0;
		// The start pulse stands only in the cycle after the drop
		step(1);
		chk({reboot_start, loading, reboot_addr}, {2'b11, exp});
		step(1);
		chk(reboot_start, 1'b0);
		reboot_req_n = 1'b1;
		load_done = 1'b1;
		step(1);
		load_done = 1'b0;
		chk(user_mode, 1'b1);
	endtask

	task automatic t_id(input int hp, input logic [1:0] tin);
		logic [65:0] got;
		u_user.run(hp, tin, got);
		chk(got, {ID_V, tin[0], tin[1]});
		step(8);
		chk(id_dout, ID_V[63]);
	endtask

	// Mid-run reset with the strap low: a reboot request is ignored
	task automatic t_strap;
		strap = 1'b0;
		rst = 1'b1;
		step(2);
		rst = 1'b0;
		step(1);
		chk({master_spi_boot, loading, user_mode}, 3'b000);
		load_start = 1'b1;
		step(1);
		load_start = 1'b0;
		load_done = 1'b1;
		step(1);
		load_done = 1'b0;
		reboot_req_n = 1'b0;
		step(2);
		chk({reboot_start, user_mode}, 2'b01);
		reboot_req_n = 1'b1;
	endtask

	initial begin
		{clk, load_start, load_done, ctrl_wr, from_user} = '0;
		{ctrl_wdata, user_addr} = '0;
		rst = 1'b1;
		reboot_req_n = 1'b1;
		strap = 1'b1;
		pin_sel = 1'b1;
		used = 8'h0f;
		uoe = 8'h05;
		uout = 8'h03;
		step(5);
		rst = 1'b0;
		step(1);
		t_reset();
		t_load();
		user_addr = 24'h0d_0000;
		t_reboot(1'b1, 24'h0d_0000);
		t_reboot(1'b0, PRESET_V);
		t_id(80, 2'b10);
		t_id(80, 2'b01);
		t_strap();
		report_and_stop();
	end

	// Tests need about 22 us; cut a hang at 300 us
	initial begin
		#300000;
		error_cnt++;
		report_and_stop();
	end
endmodule
